// ===== design/flash_sequencer.sv
`timescale 1ns/100ps
// What this block does
// R1: opcode 02h, three address bytes, data buffered
// R2: host programs 1..256 bytes into erased locations
// R3: program and erase start only with latch set
// R4: data past page end wraps within page
// R5: over 256 bytes keeps last 256 only
// R6: chip select rise programs buffered bytes, self-timed
// R7: short address, no data, ragged end abort
// R8: protected start sector: no program, back idle
// R9: program aborts clear the write latch
// R10: busy while programming, latch cleared before done
// R11: array verify failure sets fail flag
// R12: 20h/52h/D8h erase 4K/32K/64K blocks
// R13: erase takes address, ignores extra bytes
// R14: low address bits ignored per block size
// R15: short or ragged erase frame erases nothing
// R16: protected or short erase clears the latch
// R17: busy while erasing, latch cleared before done
// R18: host should poll status instead of waiting
// R19: 60h or C7h erase whole chip
// R20: partial or ragged chip erase opcode ignored
// R21: any protected sector refuses chip erase
// R22: sample input on serial clock rising edge
// R23: bytes MSB first, frames open on select
// R24: complete 06h sets the write latch
// R25: sector protection bits reset to protected
// R26: busy clears only after failure is reported
module flash_sequencer #(
    parameter int PP_CYCLES = flash_pkg::PAGE_PROGRAM_CYCLES,
    parameter int BE_CYCLES = flash_pkg::BLOCK_ERASE_CYCLES,
    parameter int CE_CYCLES = flash_pkg::CHIP_ERASE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic prot_wr,
    input wire logic [3:0] prot_sector,
    input wire logic prot_value,
    output logic [15:0] sector_prot,
    output logic busy,
    output logic write_latch_flag,
    output logic program_erase_fail_flag,
    output logic wr_valid,
    input wire logic wr_ready,
    output flash_pkg::prog_word_s wr_word,
    output logic erase_req,
    output flash_pkg::erase_cmd_s erase_cmd,
    input wire logic array_fail
);

    function automatic logic [19:0] block_base(input flash_pkg::erase_kind_e k, input logic [19:0] a);
        unique case (k)
            flash_pkg::ERASE_4K: block_base = a & flash_pkg::MASK_4K;
            flash_pkg::ERASE_32K: block_base = a & flash_pkg::MASK_32K;
            flash_pkg::ERASE_64K: block_base = a & flash_pkg::MASK_64K;
            flash_pkg::ERASE_CHIP: block_base = '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, si_s1, si_s2;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            {cs_s1, cs_s2, cs_d} <= 3'h7;
            {sck_s1, sck_s2, sck_d, si_s1, si_s2} <= 5'h0;
        end else begin
            {cs_s1, cs_s2, cs_d} <= {cs_b, cs_s1, cs_s2};
            {sck_s1, sck_s2, sck_d} <= {sck, sck_s1, sck_s2};
            {si_s1, si_s2} <= {si, si_s1};
        end
    end

    logic sck_rise, frame_end;
    assign sck_rise = sck_s2 && !sck_d;
    assign frame_end = cs_s2 && !cs_d;

    ////////////////////////////////////////////////////////////////////////////////
    // command front end
    logic [6:0] shreg, next_shreg;
    logic [2:0] bit_cnt, next_bit_cnt, byte_idx, next_byte_idx;
    logic [7:0] op, next_op, wr_idx, next_wr_idx;
    logic [23:0] addr, next_addr;
    logic [8:0] data_cnt, next_data_cnt;
    logic [7:0] page_buf [256];
    logic [7:0] next_buf [256];
    logic frame_busy, next_frame_busy, next_write_latch_flag;
    logic [15:0] next_prot;
    logic start_prog, start_erase;
    flash_pkg::erase_kind_e start_kind;

    always_comb begin
        logic [7:0] byte_in;
        logic whole, got_op, got_addr;
        byte_in = {shreg, si_s2};
        whole = bit_cnt == 3'h0;
        got_op = byte_idx != 3'h0;
        got_addr = byte_idx == flash_pkg::ADDR_DONE;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_byte_idx = byte_idx;
        next_op = op;
        next_addr = addr;
        next_wr_idx = wr_idx;
        next_data_cnt = data_cnt;
        next_buf = page_buf;
        next_write_latch_flag = write_latch_flag;
        next_frame_busy = frame_busy || busy;
        next_prot = sector_prot;
        start_prog = 1'b0;
        start_erase = 1'b0;
        start_kind = flash_pkg::ERASE_CHIP;
        if (prot_wr) begin
            next_prot[prot_sector] = prot_value;
        end
        if (cs_s2) begin
            next_bit_cnt = 3'h0;
            next_byte_idx = 3'h0;
            next_data_cnt = 9'h0;
            next_op = flash_pkg::OP_NONE;
            next_frame_busy = busy;
        end else if (sck_rise && !frame_busy && !busy) begin
            next_shreg = byte_in[6:0];  // R22 R23
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                if (byte_idx == 3'h0) begin
                    next_op = byte_in;
                end else if (byte_idx != flash_pkg::ADDR_DONE) begin
                    next_addr = {addr[15:0], byte_in};
                    next_wr_idx = byte_in;
                end else if (op == flash_pkg::OP_PROGRAM) begin
                    next_buf[wr_idx] = byte_in;  // R1 R4 R5
                    next_wr_idx = wr_idx + 8'h1;  // R4
                    if (data_cnt != flash_pkg::PAGE_BYTES) begin
                        next_data_cnt = data_cnt + 9'h1;  // R5
                    end
                end
                if (!got_addr) begin
                    next_byte_idx = byte_idx + 3'h1;  // R13
                end
            end
        end
        if (frame_end && !frame_busy && !busy) begin
            unique case (op)
                flash_pkg::OP_WRITE_ENABLE: begin
                    if (whole && got_op) begin
                        next_write_latch_flag = 1'b1;  // R24
                    end
                end
                flash_pkg::OP_PROGRAM: begin
                    if (write_latch_flag) begin  // R3
                        if (!whole || !got_addr || data_cnt == 9'h0 || sector_prot[addr[19:16]]) begin
                            next_write_latch_flag = 1'b0;  // R7 R8 R9
                        end else begin
                            start_prog = 1'b1;  // R6
                        end
                    end
                end
                flash_pkg::OP_ERASE_4K, flash_pkg::OP_ERASE_32K, flash_pkg::OP_ERASE_64K: begin
                    start_kind = op == flash_pkg::OP_ERASE_4K ? flash_pkg::ERASE_4K :
                        op == flash_pkg::OP_ERASE_32K ? flash_pkg::ERASE_32K : flash_pkg::ERASE_64K;  // R12
                    if (write_latch_flag) begin  // R3
                        if (!whole || !got_addr || sector_prot[addr[19:16]]) begin
                            next_write_latch_flag = 1'b0;  // R15 R16
                        end else begin
                            start_erase = 1'b1;  // R13
                        end
                    end
                end
                flash_pkg::OP_CHIP_A, flash_pkg::OP_CHIP_B: begin
                    if (write_latch_flag && whole && got_op) begin  // R3 R20
                        if (|sector_prot) begin
                            next_write_latch_flag = 1'b0;  // R21
                        end else begin
                            start_erase = 1'b1;  // R19
                        end
                    end
                end
                default: begin
                end
            endcase
            if (start_prog || start_erase) begin
                next_write_latch_flag = 1'b0;  // R10 R17
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            shreg <= 7'h0;
            bit_cnt <= 3'h0;
            byte_idx <= 3'h0;
            op <= flash_pkg::OP_NONE;
            addr <= 24'h0;
            wr_idx <= 8'h0;
            data_cnt <= 9'h0;
            frame_busy <= 1'b0;
            write_latch_flag <= 1'b0;
            sector_prot <= flash_pkg::PROT_RESET;  // R25
        end else begin
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            byte_idx <= next_byte_idx;
            op <= next_op;
            addr <= next_addr;
            wr_idx <= next_wr_idx;
            data_cnt <= next_data_cnt;
            frame_busy <= next_frame_busy;
            write_latch_flag <= next_write_latch_flag;
            sector_prot <= next_prot;
        end
    end

    always_ff @(posedge ref_clk) begin
        page_buf <= next_buf;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-timed execution and two-entry write buffer
    typedef enum logic {EX_IDLE, EX_RUN} exec_e;
    exec_e state, next_state;
    logic [31:0] timer, next_timer;
    logic [8:0] rd_cnt, next_rd_cnt;
    logic [7:0] rd_idx, next_rd_idx;
    logic [19:0] page_base, next_page_base;
    flash_pkg::prog_word_s fifo [2];
    flash_pkg::prog_word_s next_fifo [2];
    logic [1:0] fifo_cnt, next_fifo_cnt;
    logic rd_ptr, next_rd_ptr, push, pop, next_fail, next_erase_req;
    flash_pkg::erase_cmd_s next_erase_cmd;

    assign push = state == EX_RUN && rd_cnt != 9'h0 && fifo_cnt != 2'h2;
    assign pop = wr_valid && wr_ready;
    assign wr_valid = fifo_cnt != 2'h0;
    assign wr_word = fifo[rd_ptr];
    assign busy = state == EX_RUN;  // R10 R17

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_rd_cnt = rd_cnt;
        next_rd_idx = rd_idx;
        next_page_base = page_base;
        next_fifo = fifo;
        next_fifo_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};
        next_rd_ptr = rd_ptr ^ pop;
        next_fail = program_erase_fail_flag;
        next_erase_req = 1'b0;
        next_erase_cmd = erase_cmd;
        if (push) begin
            next_fifo[rd_ptr ^ (fifo_cnt == 2'h1)] = '{addr: {page_base[19:8], rd_idx}, data: page_buf[rd_idx]};  // R4
            next_rd_idx = rd_idx + 8'h1;
            next_rd_cnt = rd_cnt - 9'h1;
        end
        unique case (state)
            EX_IDLE: begin
                if (start_prog) begin
                    next_state = EX_RUN;
                    next_fail = 1'b0;
                    next_timer = 32'(PP_CYCLES);
                    next_rd_cnt = data_cnt;  // R6
                    next_rd_idx = addr[7:0];
                    next_page_base = addr[19:0];
                end else if (start_erase) begin
                    next_state = EX_RUN;
                    next_fail = 1'b0;
                    next_timer = start_kind == flash_pkg::ERASE_CHIP ? 32'(CE_CYCLES) : 32'(BE_CYCLES);
                    next_erase_req = 1'b1;
                    next_erase_cmd = '{kind: start_kind, base: block_base(start_kind, addr[19:0])};  // R14
                end
            end
            EX_RUN: begin
                if (array_fail) begin
                    next_fail = 1'b1;  // R11
                end
                if (timer != 32'h0) begin
                    next_timer = timer - 32'h1;
                end else if (rd_cnt == 9'h0 && fifo_cnt == 2'h0 && !array_fail) begin
                    next_state = EX_IDLE;  // R26
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= EX_IDLE;
            timer <= 32'h0;
            rd_cnt <= 9'h0;
            rd_idx <= 8'h0;
            page_base <= 20'h0;
            fifo <= '{default: '0};
            fifo_cnt <= 2'h0;
            rd_ptr <= 1'b0;
            program_erase_fail_flag <= 1'b0;
            erase_req <= 1'b0;
            erase_cmd <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            rd_cnt <= next_rd_cnt;
            rd_idx <= next_rd_idx;
            page_base <= next_page_base;
            fifo <= next_fifo;
            fifo_cnt <= next_fifo_cnt;
            rd_ptr <= next_rd_ptr;
            program_erase_fail_flag <= next_fail;
            erase_req <= next_erase_req;
            erase_cmd <= next_erase_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    start_needs_latch_a: assert property ($rose(busy) |-> $past(write_latch_flag) && !write_latch_flag)  // R3
        else $error("operation started without write latch");
    wren_sets_a: assert property (frame_end && !busy && !frame_busy && op == flash_pkg::OP_WRITE_ENABLE
        && bit_cnt == 3'h0 |=> write_latch_flag)  // R24
        else $error("write enable did not set latch");
    prot_prog_a: assert property (frame_end && op == flash_pkg::OP_PROGRAM && sector_prot[addr[19:16]]
        && !busy && !frame_busy |=> !busy && !write_latch_flag)  // R8
        else $error("program ran into protected sector");
    ragged_end_a: assert property (frame_end && bit_cnt != 3'h0 && !busy |=> !busy)  // R7
        else $error("ragged frame started an operation");
    page_wrap_a: assert property (wr_valid |-> wr_word.addr[19:8] == page_base[19:8])  // R4
        else $error("program address left its page");
    block_mask_a: assert property (erase_req && erase_cmd.kind == flash_pkg::ERASE_32K
        |-> erase_cmd.base[14:0] == 15'h0)  // R14
        else $error("erase base not aligned");
    fail_sticky_a: assert property (busy && array_fail |=> program_erase_fail_flag && busy)  // R11
        else $error("failure lost or busy dropped");
    hold_word_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
        else $error("stalled word changed");
    prot_reset_a: assert property ($rose(rst_b) |-> sector_prot == flash_pkg::PROT_RESET)  // R25
        else $error("protection not set after reset");
    chip_refuse_a: assert property (frame_end && !busy && (op == flash_pkg::OP_CHIP_A || op == flash_pkg::OP_CHIP_B)
        && |sector_prot |=> !busy)  // R21
        else $error("chip erase ran with protection");
endmodule

// ===== shared/flash_pkg.sv
package flash_pkg;
    // timing: figures in microseconds, counts at the 20 MHz ref_clk
    localparam int CLK_MHZ = 20;
    localparam int PAGE_PROGRAM_TIME_US = 1000;
    localparam int BLOCK_ERASE_TIME_US = 50000;
    localparam int CHIP_ERASE_TIME_US = 1000000;
    localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_US * CLK_MHZ;
    localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
    localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;

    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hD8;
    localparam logic [7:0] OP_CHIP_A = 8'h60;
    localparam logic [7:0] OP_CHIP_B = 8'hC7;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_NONE = 8'h00;

    localparam int ADDR_W = 20;
    localparam int SECTOR_LSB = 16;
    localparam int SECTORS = 16;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [2:0] ADDR_DONE = 3'h4;
    localparam logic [15:0] PROT_RESET = 16'hFFFF;
    localparam logic [19:0] MASK_4K = 20'hFF000;
    localparam logic [19:0] MASK_32K = 20'hF8000;
    localparam logic [19:0] MASK_64K = 20'hF0000;

    typedef enum logic [1:0] {ERASE_4K, ERASE_32K, ERASE_64K, ERASE_CHIP} erase_kind_e;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] data;
    } prog_word_s;

    typedef struct packed {
        erase_kind_e kind;
        logic [19:0] base;
    } erase_cmd_s;
endpackage

// ===== dv/spi_host.sv
`timescale 1ns/100ps
module spi_host (
    input wire logic ref_clk,
    output logic cs_b,
    output logic sck,
    output logic si
);
    logic cpol;
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        cpol = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask
    // idle level of sck between frames: 0 for mode 0, 1 for mode 3
    task automatic set_mode(input logic m);
        @(posedge ref_clk) begin
            cpol <= m;
            sck <= m;
        end
        half();
        @(negedge ref_clk);
    endtask
    // one frame: whole bytes, then loose bits of a filler byte
    task automatic frame(input logic [7:0] b[$], input int extra);
        int k;
        logic [7:0] v;
        @(posedge ref_clk) cs_b <= 1'b0;
        for (k = 0; k < 8 * b.size() + extra; k++) begin
            v = (k / 8 < b.size()) ? b[k / 8] : 8'hA5;
            si <= v[7 - k % 8];
            sck <= 1'b0;
            half();
            sck <= 1'b1;
            half();
        end
        sck <= cpol;
        half();
        cs_b <= 1'b1;
        si <= ~si; // a released line shows no stale bit
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
endmodule

// ===== dv/spi_flash_program_erase_tb.sv
`timescale 1ns/100ps
module spi_flash_program_erase_tb;
    localparam int PP = 20;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, sck, si;
    logic prot_wr = 1'b0;
    logic [3:0] prot_sector = 4'h0;
    logic prot_value = 1'b0;
    logic [15:0] sector_prot;
    logic busy, write_latch_flag, program_erase_fail_flag, wr_valid, erase_req;
    logic wr_ready = 1'b0;
    logic array_fail = 1'b0;
    flash_pkg::prog_word_s wr_word;
    flash_pkg::erase_cmd_s erase_cmd, last_cmd;
    logic [7:0] mem [256];
    logic [7:0] q [$];
    logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hD8};
    logic [19:0] bases [3] = '{20'h0A000, 20'h08000, 20'h00000};
    int n_mismatch = 0;
    int comparisons = 0;
    int n_word = 0;
    int n_erase = 0;
    int w0 = 0;
    int e0 = 0;
    int i;

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    spi_host u_spi_host (.ref_clk(ref_clk), .cs_b(cs_b), .sck(sck), .si(si));

    flash_sequencer #(.PP_CYCLES(PP), .BE_CYCLES(40), .CE_CYCLES(60)) u_flash_sequencer (
        .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .si(si),
        .prot_wr(prot_wr), .prot_sector(prot_sector), .prot_value(prot_value),
        .sector_prot(sector_prot), .busy(busy), .write_latch_flag(write_latch_flag),
        .program_erase_fail_flag(program_erase_fail_flag), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_word(wr_word), .erase_req(erase_req),
        .erase_cmd(erase_cmd), .array_fail(array_fail)
    );

    // array side: takes program words and erase pulses
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            mem <= '{default: 8'hFF};
        end else if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            mem[wr_word.addr[7:0]] <= wr_word.data;
            n_word <= n_word + 1;
        end
        if (erase_req === 1'b1) begin
            last_cmd <= erase_cmd;
            n_erase <= n_erase + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 3000 && busy !== 1'b0; n++) begin
            @(negedge ref_clk);
        end
        if (n == 3000) begin
            n_mismatch++;
            $display("BAD busy exp 0 seen 1");
            finish_test();
        end
    endtask
    task automatic prot(input int s, input logic v);
        @(posedge ref_clk) begin
            prot_wr <= 1'b1;
            prot_sector <= 4'(s);
            prot_value <= v;
        end
        @(posedge ref_clk) prot_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic wen();
        q = {8'h06};
        u_spi_host.frame(q, 0);
        chk("latch set", 32'(write_latch_flag), 32'h1);
        w0 = n_word;
        e0 = n_erase;
    endtask
    // refused frame: nothing started, latch as given
    task automatic no_op(input logic lat);
        chk("no busy", 32'(busy), 32'h0);
        chk("latch", 32'(write_latch_flag), 32'(lat));
        chk("no words", 32'(n_word - w0), 32'h0);
        chk("no erase", 32'(n_erase - e0), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        chk("prot reset", 32'(sector_prot), 32'h0000FFFF);
        chk("idle", 32'({busy, write_latch_flag, program_erase_fail_flag}), 32'h0);
        prot(0, 1'b0);
        chk("unprot 0", 32'(sector_prot), 32'h0000FFFE);
        q = {8'h02, 8'h00, 8'h00, 8'h10, 8'h55};
        u_spi_host.frame(q, 0);
        no_op(1'b0);
        // wrap inside the page while the array stalls
        wen();
        q = {8'h02, 8'h00, 8'h00, 8'hFE, 8'h11, 8'h22, 8'h33};
        u_spi_host.frame(q, 0);
        chk("prog busy", 32'(busy), 32'h1);
        chk("prog latch", 32'(write_latch_flag), 32'h0);
        chk("stall valid", 32'(wr_valid), 32'h1);
        chk("first word", 32'(wr_word), {4'h0, 20'h000FE, 8'h11});
        repeat (PP + 10) @(negedge ref_clk);
        chk("busy stalled", 32'(busy), 32'h1);
        chk("held word", 32'(wr_word), {4'h0, 20'h000FE, 8'h11});
        @(posedge ref_clk) wr_ready <= 1'b1;
        wait_idle();
        chk("words", 32'(n_word - w0), 32'h3);
        chk("byte FE", 32'(mem[8'hFE]), 32'h11);
        chk("byte FF", 32'(mem[8'hFF]), 32'h22);
        chk("byte 00", 32'(mem[8'h00]), 32'h33);
        chk("byte 01", 32'(mem[8'h01]), 32'hFF);
        // over-long page keeps the last 256
        wen();
        q = {8'h02, 8'h00, 8'h00, 8'h00};
        for (i = 0; i < 258; i++) q.push_back(i < 256 ? 8'(i) : 8'(i - 96));
        u_spi_host.frame(q, 0);
        wait_idle();
        chk("count 256", 32'(n_word - w0), 32'd256);
        chk("last 0", 32'(mem[0]), 32'hA0);
        chk("last 1", 32'(mem[1]), 32'hA1);
        chk("keep 2", 32'(mem[2]), 32'h02);
        // aborted programs
        wen();
        q = {8'h02, 8'h00, 8'h01, 8'h00};
        u_spi_host.frame(q, 0);
        no_op(1'b0);
        wen();
        q = {8'h02, 8'h00, 8'h01, 8'h00, 8'h12};
        u_spi_host.frame(q, 3);
        no_op(1'b0);
        wen();
        q = {8'h02, 8'h01, 8'h00, 8'h00, 8'h12};
        u_spi_host.frame(q, 0);
        no_op(1'b0);
        // block erase per size, extra byte ignored, one failure injected
        for (i = 0; i < 3; i++) begin
            wen();
            q = {ops[i], 8'h00, 8'hAB, 8'hCD, 8'h77};
            u_spi_host.frame(q, 0);
            chk("erase pulse", 32'(n_erase - e0), 32'h1);
            chk("erase kind", 32'(last_cmd.kind), 32'(i));
            chk("erase base", 32'(last_cmd.base), 32'(bases[i]));
            chk("erase busy", 32'(busy), 32'h1);
            chk("erase latch", 32'(write_latch_flag), 32'h0);
            if (i == 0) begin
                @(posedge ref_clk) array_fail <= 1'b1;
                @(posedge ref_clk) array_fail <= 1'b0;
            end
            wait_idle();
            chk("fail flag", 32'(program_erase_fail_flag), 32'(i == 0));
        end
        wen();
        q = {8'h20, 8'h00, 8'hAB};
        u_spi_host.frame(q, 0);
        no_op(1'b0);
        wen();
        q = {8'h20, 8'h00, 8'hAB, 8'hCD};
        u_spi_host.frame(q, 5);
        no_op(1'b0);
        wen();
        q = {8'h52, 8'h01, 8'h00, 8'h00};
        u_spi_host.frame(q, 0);
        no_op(1'b0);
        // chip erase
        wen();
        q = {8'hC7};
        u_spi_host.frame(q, 0);
        no_op(1'b0);
        for (i = 0; i < 16; i++) prot(i, 1'b0);
        chk("all unprot", 32'(sector_prot), 32'h0);
        for (i = 0; i < 2; i++) begin
            if (i == 1) u_spi_host.set_mode(1'b1);
            wen();
            q = {(i == 0) ? 8'h60 : 8'hC7, 8'h55};
            u_spi_host.frame(q, 0);
            chk("chip pulse", 32'(n_erase - e0), 32'h1);
            chk("chip kind", 32'(last_cmd.kind), 32'(flash_pkg::ERASE_CHIP));
            chk("chip busy", 32'(busy), 32'h1);
            wait_idle();
        end
        wen();
        q = {8'h60};
        u_spi_host.frame(q, 4);
        no_op(1'b1);
        q = {};
        u_spi_host.frame(q, 5);
        no_op(1'b1);
        finish_test();
    end
endmodule
